// ===== rtl/adc_backend_consts.svh
// Purpose: Constants of the converter digital back end
// Assumes: Included by package and design files
// Notes:   Counts are in sample cycles unless named otherwise
`ifndef ADC_BACKEND_CONSTS_SVH
`define ADC_BACKEND_CONSTS_SVH

// Datapath widths
`define WORD_W          8
`define STAGE_W         2
`define STAGE_CNT       7
`define SUM_W           10
`define FULL_SCALE      8'hff

// Delay line depth for the first stage pair
`define DLY_MAX         3

// Stage sampling masks: even stages sample with the sampling phase
`define EVEN_STAGE_MASK 7'h55

// Sample clock built from core clock cycles: sample, gap, hold, gap
`define CORE_PER_SAMPLE 4

// Latency and power-up interval in sample cycles
`define LAT_CYCLES      7
`define INIT_CYCLES     20
`define INIT_CNT_W      5
`define INIT_RST        5'h00

// Output buffer
`define FIFO_DEPTH      4

`endif

// ===== rtl/adc_backend_pkg.sv
// Purpose: Types and the output coding function of the back end
// Assumes: adc_backend_consts.svh present
// Notes:   Holds no numbers of its own
`include "adc_backend_consts.svh"

package adc_backend_pkg;

  typedef logic [`WORD_W-1:0]  word_t;
  typedef logic [`STAGE_W-1:0] stage_word_t;
  typedef logic [`SUM_W-1:0]   sum_t;

  typedef enum logic [1:0] {PH_SAMP, PH_GAP1, PH_HOLD, PH_GAP2} phase_t;

  typedef struct packed {
    phase_t                                          phase;
    logic [`INIT_CNT_W-1:0]                          initCnt;
    logic                                            initDone;
    logic [`STAGE_CNT-1:0][`DLY_MAX-1:0][`STAGE_W-1:0] dly;
    word_t                                           latch1;
    logic                                            latch1Full;
    word_t                                           latch2;
    logic                                            strobe;
  } core_state_t;

  // Two's complement differs from offset binary only in the MSB
  function automatic word_t fmtWord(word_t w, logic twos);
    return twos ? {~w[`WORD_W-1], w[`WORD_W-2:0]} : w;
  endfunction

endpackage

// ===== rtl/word_stream_if.sv
// Purpose: Valid/ready word carrier between back end and buffer
// Assumes: One clock domain
// Notes:   No clocking block; plain handshake
`timescale 1ns/1ps
`default_nettype none

interface word_stream_if #(
  parameter int W = 8
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== rtl/sample_fifo.sv
// Purpose: Small word buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Head word is read straight from the storage registers
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic  clk,
  input  wire logic  rstN,
  input  wire logic  clkEn,
  word_stream_if.snk pushSide,
  word_stream_if.src popSide
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 fill;
  } fifo_state_t;

  fifo_state_t st_q;
  fifo_state_t st_d;
  logic        doPush;
  logic        doPop;

  assign pushSide.ready = (st_q.fill != (AW+1)'(DEPTH));
  assign popSide.valid  = (st_q.fill != '0);
  assign popSide.data   = st_q.mem[st_q.rdPtr];
  assign doPush         = clkEn && pushSide.valid && pushSide.ready;
  assign doPop          = clkEn && popSide.valid && popSide.ready;

  always_comb begin
    st_d = st_q;
    if (doPush) begin
      st_d.mem[st_q.wrPtr] = pushSide.data;
      st_d.wrPtr           = st_q.wrPtr + 1'b1;
    end
    if (doPop) begin
      st_d.rdPtr = st_q.rdPtr + 1'b1;
    end
    case ({doPush, doPop})
      2'b10:   st_d.fill = st_q.fill + 1'b1;
      2'b01:   st_d.fill = st_q.fill - 1'b1;
      default: st_d.fill = st_q.fill;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/adc_backend.sv
// Purpose: Digital back end of a pipelined sampling converter
// Assumes: Stage i presents its word for sample N before the tick
//          that closes sample cycle N+1+i/2
// Notes:   One sample cycle spans four core clock cycles
//
// Contract
// - Word appears seventh sample cycle after sampling
// - Outputs invalid for twenty cycles after power-up
// - Then one new word every sample cycle
// - Output passes two latch stages before bus
// - Format select chooses offset binary or two's complement
// - Two internal phases never overlap
// - Sampling phase connects input, clears hold; capture
// - Holding phase joins samplers, holds onto amplifier
// - Identical two-bit stages plus final two-bit stage
// - Alternate stages sample in opposite phases
// - Each stage word carries one redundant bit
// - Delay line aligns stage words with final
// - Correction merges aligned words using redundant bits
// - Full scale: all ones, or 0 then ones
`timescale 1ns/1ps
`default_nettype none
`include "adc_backend_consts.svh"

module adc_backend
  import adc_backend_pkg::*;
(
  input  wire logic                              core_clk,
  input  wire logic                              arst_n,
  input  wire logic                              clkEn,
  input  wire logic                              formatSelect,
  input  wire logic                              outputEnable_n,
  input  wire logic                              rxStall,
  input  wire logic [`STAGE_CNT-1:0][`STAGE_W-1:0] stageWord,
  output logic                                   sampPhase,
  output logic                                   holdPhase,
  output logic                                   captureStrobe,
  output logic      [`STAGE_CNT-1:0]             stageSample,
  output logic                                   stageReady,
  output logic      [`WORD_W-1:0]                dataOut,
  output logic                                   busDriveEn_n,
  output logic                                   dataValid,
  output logic                                   wordStrobe
);

  // Reset release: asserted at once, released after two edges
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  core_state_t st_q;
  core_state_t st_d;

  logic                          tick;
  stage_word_t [`STAGE_CNT-1:0]  aligned;
  sum_t                          corrSum;
  word_t                         corrWord;
  logic                          pop;
  logic                          xfer;

  word_stream_if #(.W(`WORD_W)) fifoIn ();
  word_stream_if #(.W(`WORD_W)) fifoOut ();

  // Internal clock phases, separated by one idle core cycle each
  // non-overlapping phases
  assign sampPhase     = (st_q.phase == PH_SAMP);
  assign holdPhase     = (st_q.phase == PH_HOLD);
  assign captureStrobe = (st_q.phase == PH_GAP1);
  // Closing edge of each sample cycle
  assign tick          = (st_q.phase == PH_GAP2);

  // Per-stage clocking and alignment taps
  for (genvar i = 0; i < `STAGE_CNT; i++) begin : g_stage
    localparam int Dly = `DLY_MAX - i / 2;
    assign stageSample[i] = (i % 2 == 0) ? sampPhase : holdPhase;
    if (Dly == 0) begin : g_direct
      assign aligned[i] = stageWord[i];
    end else begin : g_delayed
      assign aligned[i] = st_q.dly[i][Dly-1];
    end
  end

  // Stage words overlap by one bit; the redundant bit is absorbed by the
  // sum, and a total sum above full scale saturates instead of wrapping
  always_comb begin
    corrSum = '0;
    for (int i = 0; i < `STAGE_CNT - 1; i++) begin
      corrSum = corrSum + (sum_t'(aligned[i]) << (`STAGE_CNT - 1 - i));
    end
    corrSum = corrSum + sum_t'(aligned[`STAGE_CNT-1]);
    if (corrSum > sum_t'(`FULL_SCALE)) begin
      corrWord = `FULL_SCALE;
    end else begin
      corrWord = corrSum[`WORD_W-1:0];
    end
  end

  // Corrected words enter the buffer once per sample cycle
  assign fifoIn.valid  = tick && clkEn;
  assign fifoIn.data   = corrWord;
  assign stageReady    = fifoIn.ready;
  assign fifoOut.ready = tick && clkEn && !rxStall;
  assign pop           = fifoOut.valid && fifoOut.ready;
  assign xfer          = tick && !rxStall && st_q.latch1Full;

  sample_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rstN     (rstN),
    .clkEn    (clkEn),
    .pushSide (fifoIn),
    .popSide  (fifoOut)
  );

  always_comb begin
    st_d = st_q;
    if (clkEn) begin
      st_d.strobe = 1'b0;
      case (st_q.phase)
        PH_SAMP: begin
          st_d.phase = PH_GAP1;
        end
        PH_GAP1: begin
          st_d.phase = PH_HOLD;
        end
        PH_HOLD: begin
          st_d.phase = PH_GAP2;
        end
        PH_GAP2: begin
          st_d.phase = PH_SAMP;
        end
        default: begin
          st_d.phase = PH_SAMP;
        end
      endcase
      if (tick) begin
        if (!st_q.initDone) begin
          if (st_q.initCnt == `INIT_CNT_W'(`INIT_CYCLES - 1)) begin
            st_d.initDone = 1'b1;
          end else begin
            st_d.initCnt = st_q.initCnt + 1'b1;
          end
        end
        // A full buffer freezes the alignment; words offered then are lost
        // delay line shift
        if (fifoIn.ready) begin
          for (int i = 0; i < `STAGE_CNT; i++) begin
            st_d.dly[i][0] = stageWord[i];
            for (int k = 1; k < `DLY_MAX; k++) begin
              st_d.dly[i][k] = st_q.dly[i][k-1];
            end
          end
        end
        if (xfer) begin
          st_d.latch2 = st_q.latch1;
          st_d.strobe = 1'b1;
        end
        if (pop) begin
          st_d.latch1     = fmtWord(fifoOut.data, formatSelect);
          st_d.latch1Full = 1'b1;
        end else if (xfer) begin
          st_d.latch1Full = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      st_q         <= '0;
      st_q.phase   <= PH_SAMP;
      st_q.initCnt <= `INIT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wordStrobe   = st_q.strobe;
  assign dataValid    = st_q.initDone;
  assign dataOut      = st_q.latch2;
  assign busDriveEn_n = outputEnable_n;

  // Checks below assume the clock enable is high; a freeze aborts them
  logic [5:0] tickCnt;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      tickCnt <= 6'h00;
    end else if (clkEn && tick && tickCnt != 6'h3f) begin
      tickCnt <= tickCnt + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!rstN || !clkEn);

  sequence s_pushIdle;
    tick && fifoIn.valid && fifoIn.ready && !fifoOut.valid && !rxStall;
  endsequence

  sequence s_pop;
    tick && pop;
  endsequence

  property p_latency;
    s_pushIdle ##1 (!rxStall)[*8] |=>
      dataOut == fmtWord($past(corrWord, 9), $past(formatSelect, 5));
  endproperty
  a_latency: assert property (p_latency)
    else $error("corrected word missed its output slot");

  property p_initInterval;
    $rose(dataValid) |-> tickCnt == 6'(`INIT_CYCLES);
  endproperty
  a_initInterval: assert property (p_initInterval)
    else $error("data valid not after twenty sample cycles");

  property p_initHold;
    tick && tickCnt < 6'(`INIT_CYCLES - 1) |=> !dataValid;
  endproperty
  a_initHold: assert property (p_initHold)
    else $error("data valid raised inside the power-up interval");

  property p_onePerCycle;
    wordStrobe && st_q.latch1Full ##1 (!rxStall)[*3] |=> wordStrobe;
  endproperty
  a_onePerCycle: assert property (p_onePerCycle)
    else $error("sample word missing in following cycle");

  property p_double;
    s_pop ##1 (!rxStall)[*4] |=>
      wordStrobe && dataOut == fmtWord($past(fifoOut.data, 5), $past(formatSelect, 5));
  endproperty
  a_double: assert property (p_double)
    else $error("word did not pass both latch stages");

  property p_stallHold;
    tick && rxStall |=> !wordStrobe && $stable(dataOut);
  endproperty
  a_stallHold: assert property (p_stallHold)
    else $error("output latch moved during a stall");

  property p_frozenAlign;
    tick && !stageReady |=> $stable(st_q.dly);
  endproperty
  a_frozenAlign: assert property (p_frozenAlign)
    else $error("delay line moved while the buffer was full");

  property p_nonOverlap;
    sampPhase |=> !holdPhase ##1 holdPhase;
  endproperty
  a_nonOverlap: assert property (p_nonOverlap)
    else $error("phases overlap or lack a gap");

  property p_capture;
    $fell(sampPhase) |-> captureStrobe && !holdPhase;
  endproperty
  a_capture: assert property (p_capture)
    else $error("no capture at sampling phase end");

  property p_hold;
    holdPhase |=> !sampPhase ##1 sampPhase;
  endproperty
  a_hold: assert property (p_hold)
    else $error("holding phase not followed by sampling");

  property p_alternate;
    (sampPhase |-> stageSample == `EVEN_STAGE_MASK) and
    (holdPhase |-> stageSample == ~`EVEN_STAGE_MASK);
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("stage phases do not alternate");

  property p_fullScale;
    tick && corrSum >= sum_t'(`FULL_SCALE) |-> corrWord == `FULL_SCALE;
  endproperty
  a_fullScale: assert property (p_fullScale)
    else $error("full scale code wrong");

endmodule

`default_nettype wire

// ===== test/word_receiver.sv
// Purpose: Receiving logic model that captures sample words
// Assumes: Words are taken on the core clock with the word strobe
// Notes:   Stall is driven by the bench through holdOff
`timescale 1ns/1ps
`default_nettype none

module word_receiver
  import adc_backend_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  input  wire logic  holdOff,
  input  wire logic  wordStrobe,
  input  wire logic  dataValid,
  input  wire word_t dataBus,
  output logic       rxStall,
  output word_t      lastWord,
  output int         wordCount
);
  assign rxStall = holdOff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastWord <= '0;
      wordCount <= 0;
    end else if (wordStrobe && dataValid) begin
      lastWord <= dataBus;
      wordCount <= wordCount + 1;
    end
  end
endmodule

`default_nettype wire

// ===== test/pipelined_adc_digital_backend_bench.sv
// Purpose: Self-checking bench of the converter back end
// Assumes: Receiver model in word_receiver.sv
// Notes:   Inputs change on the falling edge; clkEn drops once to freeze
`timescale 1ns/1ps
`default_nettype none
`include "adc_backend_consts.svh"

module pipelined_adc_digital_backend_bench;
  import adc_backend_pkg::*;
  logic                                core_clk, arst_n, formatSelect, outputEnable_n, holdOff;
  logic                                clkEn;
  logic [`STAGE_CNT-1:0][`STAGE_W-1:0] stageWord;
  logic                                sampPhase, holdPhase, captureStrobe, stageReady;
  logic                                busDriveEn_n, dataValid, wordStrobe, rxStall;
  logic [`STAGE_CNT-1:0]               stageSample;
  word_t                               dataOut, lastWord;
  int                                  wordCount, miscompares, n_checks;
  tri0  [`WORD_W-1:0]                  dataBus;

  // Released bus falls to the pull-down level, never the last word
  assign dataBus = busDriveEn_n ? 'z : dataOut;

  adc_backend u_dut (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .formatSelect(formatSelect),
    .outputEnable_n(outputEnable_n), .rxStall(rxStall), .stageWord(stageWord), .sampPhase(sampPhase),
    .holdPhase(holdPhase), .captureStrobe(captureStrobe), .stageSample(stageSample),
    .stageReady(stageReady), .dataOut(dataOut), .busDriveEn_n(busDriveEn_n), .dataValid(dataValid),
    .wordStrobe(wordStrobe));
  word_receiver u_rx (.core_clk(core_clk), .arst_n(arst_n), .holdOff(holdOff), .wordStrobe(wordStrobe),
    .dataValid(dataValid), .dataBus(dataBus), .rxStall(rxStall), .lastWord(lastWord),
    .wordCount(wordCount));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chkWord(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Weighted sum of stage words, clipped at full scale
  function automatic word_t expWord(input logic [6:0][1:0] s, input logic twos);
    int sum;
    sum = s[6];
    for (int i = 0; i < 6; i++) sum += s[i] << (6 - i);
    if (sum > 255) sum = 255;
    return twos ? word_t'(sum ^ 8'h80) : word_t'(sum);
  endfunction

  task automatic waitStrobes(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 1000) begin
      @(negedge core_clk);
      k++;
      if (wordStrobe === 1'b1) n--;
    end
    chkBit(n == 0, 1'b1);
  endtask

  task automatic tInit();
    int k;
    repeat (60) @(negedge core_clk);
    chkBit(dataValid, 1'b0);
    k = 0;
    while (dataValid !== 1'b1 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    chkBit(dataValid, 1'b1);
    chkWord(8'(wordCount), 8'h00);
  endtask

  task automatic tPhases();
    logic prevSamp;
    prevSamp = sampPhase;
    repeat (16) begin
      @(negedge core_clk);
      chkBit(sampPhase & holdPhase, 1'b0);
      chkBit(captureStrobe, prevSamp & ~sampPhase);
      chkWord({1'b0, stageSample}, {1'b0, {7{sampPhase}} & 7'h55 | {7{holdPhase}} & 7'h2a});
      prevSamp = sampPhase;
    end
  endtask

  task automatic tCadence();
    int gap;
    waitStrobes(1);
    for (int k = 0; k < 4; k++) begin
      gap = 0;
      do begin
        @(negedge core_clk);
        gap++;
      end while (wordStrobe !== 1'b1 && gap < 20);
      chkWord(8'(gap), 8'h04);
    end
  endtask

  task automatic tFormat();
    logic [6:0][1:0] pat [4];
    pat[0] = {7{2'h3}};
    pat[1] = {7{2'h1}};
    pat[2] = '0;
    pat[3] = {2'h2, 2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h1};
    for (int p = 0; p < 4; p++) begin
      for (int f = 0; f < 2; f++) begin
        stageWord = pat[p];
        formatSelect = f[0];
        waitStrobes(10);
        chkWord(dataBus, expWord(pat[p], f[0]));
        @(negedge core_clk);
        chkWord(lastWord, expWord(pat[p], f[0]));
      end
    end
  endtask

  task automatic tStall();
    word_t held;
    int k;
    waitStrobes(1);
    held = dataOut;
    holdOff = 1'b1;
    k = 0;
    while (stageReady !== 1'b0 && k < 60) begin
      @(negedge core_clk);
      k++;
      chkBit(wordStrobe, 1'b0);
    end
    chkBit(stageReady, 1'b0);
    chkWord(dataOut, held);
    holdOff = 1'b0;
    waitStrobes(8);
    chkBit(stageReady, 1'b1);
    chkWord(dataOut, expWord(stageWord, formatSelect));
  endtask

  // Freeze starts one cycle after a strobe so the strobe is not held high
  task automatic tFreeze();
    logic [2:0] ph;
    word_t      held;
    waitStrobes(1);
    @(negedge core_clk);
    ph = {sampPhase, captureStrobe, holdPhase};
    held = dataOut;
    clkEn = 1'b0;
    repeat (8) begin
      @(negedge core_clk);
      chkWord({5'h00, sampPhase, captureStrobe, holdPhase}, {5'h00, ph});
      chkBit(wordStrobe, 1'b0);
      chkWord(dataOut, held);
    end
    clkEn = 1'b1;
    waitStrobes(2);
    chkWord(dataOut, expWord(stageWord, formatSelect));
  endtask

  task automatic tEnable();
    outputEnable_n = 1'b1;
    @(negedge core_clk);
    chkBit(busDriveEn_n, 1'b1);
    chkWord(dataBus, 8'h00);
    outputEnable_n = 1'b0;
    @(negedge core_clk);
    chkWord(dataBus, expWord(stageWord, formatSelect));
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    miscompares = 0;
    n_checks = 0;
    arst_n = 1'b0;
    formatSelect = 1'b0;
    outputEnable_n = 1'b0;
    holdOff = 1'b0;
    clkEn = 1'b1;
    stageWord = '0;
    repeat (5) @(negedge core_clk);
    chkBit(sampPhase, 1'b1);
    chkWord(dataOut, 8'h00);
    chkBit(dataValid, 1'b0);
    arst_n = 1'b1;
    tInit();
    tPhases();
    tCadence();
    tFormat();
    tStall();
    tFreeze();
    tEnable();
    tally_and_finish();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #100us;
    miscompares++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
